// ### hw/hpsm_pkg.sv
package hpsm_pkg;

	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [7:0] SETTINGS_OFS  = 8'h00;
	localparam logic [7:0] STATE_OFS     = 8'h04;

	// Settings register fields
	localparam int MODE_LSB    = 0;
	localparam int MODE_W      = 2;
	localparam int TIMEOUT_LSB = 8;
	localparam int TIMEOUT_W   = 8;

	// State register fields
	localparam int ST_SLEEP_BIT  = 0;
	localparam int ST_WAKING_BIT = 1;
	localparam int ST_RUN_BIT    = 2;
	localparam int ST_IFACE_BIT  = 3;

	// ---------------------------------------------------------------
	// Power modes
	// ---------------------------------------------------------------
	localparam logic [1:0] MODE_QUICK = 2'h0;
	localparam logic [1:0] MODE_DEEP  = 2'h1;
	localparam logic [1:0] MODE_AUTO  = 2'h2;

	localparam logic [1:0] MODE_RST    = MODE_AUTO;
	localparam logic [7:0] TIMEOUT_RST = 8'h01;

	typedef enum logic [1:0] {
		deep_sleep_state,
		waking_state,
		quick_state
	} hpsm_state_type;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int unsigned CLK_KHZ      = 200_000;
	localparam int unsigned STEP_MS      = 512;
	localparam int unsigned STEP_CYC     = CLK_KHZ * STEP_MS;
	localparam int unsigned WAKE_MIN_US  = 300;
	localparam int unsigned WAKE_CYC     = (WAKE_MIN_US * CLK_KHZ + 999) / 1000;
	localparam int unsigned STRAP_WAIT   = 3;

endpackage : hpsm_pkg

// ### hw/hpsm_sync2.sv
`timescale 1ns/1ps
module hpsm_sync2 #(
	parameter int W = 1
) (
	input  wire logic         clock,
	input  wire logic         resetn,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	import hpsm_pkg::*;

	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] dout_nxt;

	always_comb begin
		meta_nxt = din;
		dout_nxt = meta_r;
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			meta_r <= '0;
			dout   <= '0;
		end else begin
			meta_r <= meta_nxt;
			dout   <= dout_nxt;
		end
	end

endmodule : hpsm_sync2

// ### hw/hpsm_tick.sv
`timescale 1ns/1ps
module hpsm_tick #(
	parameter int unsigned DIV = 16
) (
	input  wire logic clock,
	input  wire logic resetn,
	input  wire logic clear,
	output logic      tick
);
	import hpsm_pkg::*;

	logic [31:0] cnt_r;
	logic [31:0] cnt_nxt;
	logic        tick_nxt;

	// One pulse per step; clear restarts the step from zero
	always_comb begin
		tick_nxt = 1'b0;
		cnt_nxt  = cnt_r + 32'h1;
		if (clear) begin
			cnt_nxt = 32'h0;
		end else if (cnt_r == 32'(DIV - 1)) begin
			cnt_nxt  = 32'h0;
			tick_nxt = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			cnt_r <= 32'h0;
			tick  <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick  <= tick_nxt;
		end
	end

endmodule : hpsm_tick

// ### hw/hpsm_top.sv
// Overview of operation
// [R1] After reset, sample interface select pin once: low serial, high pulse mode.
// [R2] Two power states only: quick response and deep sleep; the code adds a third, waking_state, between them.
// [R3] Motor drive outputs are tri-stated while in deep sleep.
// [R4] Wake from deep sleep takes the wake interval before a pulse starts.
// [R5] Quick response keeps core up, pulse starts right after trigger.
// [R6] A trigger command wakes the device from any sleep state.
// [R7] While pulse running flag is set, no sleep happens.
// [R8] Three modes: quick forces quick, deep forces deep, automatic manages.
// [R9] Automatic mode goes quick on trigger command or serial addressing.
// [R10] Automatic mode sleeps after timeout field times 512 ms.
// [R11] Timeout restarts during haptics, on addressing, and while trigger pin high.
// [R12] Trigger pin high blocks deep sleep in every mode.
// [R13] Timeout counts from pulse end, or from trigger pin fall if later.
// [R14] Current power state is readable in the state register.
// [R15] Host sets power mode and timeout in the settings register.
// [R16] Pulse running flag is held for the whole waveform.
// [R17] Sampled interface mode is held until next reset.
// [R18] Timeout uses a prescaled 512 ms tick compared to the field.
`timescale 1ns/1ps
module hpsm_top #(
	parameter int unsigned STEP_CYC = hpsm_pkg::STEP_CYC,
	parameter int unsigned WAKE_CYC = hpsm_pkg::WAKE_CYC
) (
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        iface_sel_pin,
	input  wire logic        trig_pin,
	input  wire logic        trigger_cmd,
	input  wire logic        serial_addressed,
	input  wire logic        waveform_busy,
	input  wire logic        drive_p,
	input  wire logic        drive_n,
	output logic             pulse_go,
	output logic             pulse_running,
	output logic             iface_pulse_mode,
	output logic             deep_sleep,
	output logic             motor_p_o,
	output logic             motor_p_oe,
	output logic             motor_n_o,
	output logic             motor_n_oe
);
	import hpsm_pkg::*;

	// ---------------------------------------------------------------
	// Pin synchronisers and step prescaler
	// ---------------------------------------------------------------
	logic [1:0] pins_s;
	logic       sel_s;
	logic       trig_s;
	logic       restart;
	logic       tick;

	hpsm_sync2 #(.W(2)) u_sync (
		.clock  (clock),
		.resetn (resetn),
		.din    ({iface_sel_pin, trig_pin}),
		.dout   (pins_s)
	);
	assign sel_s  = pins_s[1];
	assign trig_s = pins_s[0];

	hpsm_tick #(.DIV(STEP_CYC)) u_tick (
		.clock  (clock),
		.resetn (resetn),
		.clear  (restart),
		.tick   (tick)
	);

	// ---------------------------------------------------------------
	// APB slave
	// ---------------------------------------------------------------
	function automatic logic hit(input logic [31:0] a, input logic [7:0] ofs);
		hit = (a == {24'h0, ofs});
	endfunction : hit

	logic [1:0]     mode_r;
	logic [1:0]     mode_nxt;
	logic [7:0]     timeout_r;
	logic [7:0]     timeout_nxt;
	logic [31:0]    prdata_nxt;
	logic           mapped;
	logic           wr_acc;
	hpsm_state_type state_r;
	hpsm_state_type state_nxt;
	logic           iface_r;
	logic           run_r;

	assign mapped  = hit(paddr, SETTINGS_OFS) || hit(paddr, STATE_OFS);
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign wr_acc  = psel && penable && pwrite && mapped;

	always_comb begin
		mode_nxt    = mode_r;
		timeout_nxt = timeout_r;
		prdata_nxt  = prdata;
		if (wr_acc && hit(paddr, SETTINGS_OFS)) begin
			mode_nxt    = pwdata[MODE_LSB +: MODE_W];        // R15
			timeout_nxt = pwdata[TIMEOUT_LSB +: TIMEOUT_W];
		end
		if (psel && !penable && !pwrite) begin
			prdata_nxt = 32'h0;
			if (hit(paddr, SETTINGS_OFS)) begin
				prdata_nxt[MODE_LSB +: MODE_W]       = mode_r;
				prdata_nxt[TIMEOUT_LSB +: TIMEOUT_W] = timeout_r;
			end else if (hit(paddr, STATE_OFS)) begin
				prdata_nxt[ST_SLEEP_BIT]  = (state_r == deep_sleep_state); // R14
				prdata_nxt[ST_WAKING_BIT] = (state_r == waking_state);
				prdata_nxt[ST_RUN_BIT]    = run_r;
				prdata_nxt[ST_IFACE_BIT]  = iface_r;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			mode_r    <= MODE_RST;
			timeout_r <= TIMEOUT_RST;
			prdata    <= 32'h0;
		end else begin
			mode_r    <= mode_nxt;
			timeout_r <= timeout_nxt;
			prdata    <= prdata_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Interface strap capture
	// ---------------------------------------------------------------
	logic [1:0] strap_cnt_r;
	logic [1:0] strap_cnt_nxt;
	logic       captured_r;
	logic       captured_nxt;
	logic       iface_nxt;

	// Wait for the synchroniser to fill, then sample exactly once
	always_comb begin
		strap_cnt_nxt = strap_cnt_r;
		captured_nxt  = captured_r;
		iface_nxt     = iface_r;
		if (!captured_r) begin
			if (strap_cnt_r == 2'(STRAP_WAIT - 1)) begin
				captured_nxt = 1'b1;                             // R1
				iface_nxt    = sel_s;                            // R1
			end else begin
				strap_cnt_nxt = strap_cnt_r + 2'h1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			strap_cnt_r <= 2'h0;
			captured_r  <= 1'b0;
			iface_r     <= 1'b0;
		end else begin
			strap_cnt_r <= strap_cnt_nxt;
			captured_r  <= captured_nxt;
			iface_r     <= iface_nxt;                         // R17
		end
	end

	// ---------------------------------------------------------------
	// Automatic timeout
	// ---------------------------------------------------------------
	logic [7:0] steps_r;
	logic [7:0] steps_nxt;
	logic       hold_r;
	logic       hold_nxt;
	logic       expire;
	logic       pend_r;

	// Held high through pulses and trigger pin, so count starts at the later end
	assign restart = run_r || waveform_busy || serial_addressed || trig_s
		|| trigger_cmd || pend_r || pulse_go;                 // R11 R13
	assign expire  = !restart && (steps_r >= timeout_r);     // R18

	always_comb begin
		steps_nxt = steps_r;
		hold_nxt  = hold_r;
		if (restart) begin
			steps_nxt = 8'h0;
		end else if (tick && steps_r != 8'hff) begin
			steps_nxt = steps_r + 8'h1;                          // R18
		end
		if (trigger_cmd || serial_addressed) begin
			hold_nxt = 1'b1;                                     // R9
		end else if (expire) begin
			hold_nxt = 1'b0;                                     // R10
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			steps_r <= 8'h0;
			hold_r  <= 1'b1;
		end else begin
			steps_r <= steps_nxt;
			hold_r  <= hold_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Power state machine
	// ---------------------------------------------------------------
	logic [31:0] wake_cnt_r;
	logic [31:0] wake_cnt_nxt;
	logic        pend_nxt;
	logic        go_nxt;
	logic        run_nxt;
	logic        want_awake;

	always_comb begin
		case (mode_r)
			MODE_QUICK: want_awake = 1'b1;                       // R8
			MODE_DEEP:  want_awake = 1'b0;                       // R8
			default:    want_awake = hold_r;                     // R10
		endcase
		// Bridge the gap between pulse start and the running flag
		want_awake = want_awake || trig_s || run_r || pend_r || pulse_go
			|| waveform_busy || trigger_cmd;                     // R6 R7 R12
	end

	always_comb begin
		state_nxt    = state_r;
		wake_cnt_nxt = wake_cnt_r;
		go_nxt       = 1'b0;
		run_nxt      = waveform_busy;                          // R16
		pend_nxt     = pend_r;
		case (state_r)
			deep_sleep_state: begin
				wake_cnt_nxt = 32'h0;
				if (want_awake) begin
					state_nxt = waking_state;                        // R6
				end
			end
			waking_state: begin
				if (wake_cnt_r == 32'(WAKE_CYC - 1)) begin
					state_nxt = quick_state;                         // R4
				end else begin
					wake_cnt_nxt = wake_cnt_r + 32'h1;
				end
			end
			quick_state: begin
				if (pend_r) begin
					go_nxt   = 1'b1;                                 // R5
					pend_nxt = 1'b0;
				end
				if (!want_awake) begin
					state_nxt = deep_sleep_state;                    // R2
				end
			end
			default: state_nxt = deep_sleep_state;
		endcase
		if (trigger_cmd) begin
			pend_nxt = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			state_r    <= quick_state;
			wake_cnt_r <= 32'h0;
			pend_r     <= 1'b0;
			pulse_go   <= 1'b0;
			run_r      <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			wake_cnt_r <= wake_cnt_nxt;
			pend_r     <= pend_nxt;
			pulse_go   <= go_nxt;
			run_r      <= run_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Motor outputs
	// ---------------------------------------------------------------
	logic drv_oe_nxt;
	logic mp_nxt;
	logic mn_nxt;

	always_comb begin
		drv_oe_nxt = (state_nxt == quick_state);               // R3
		mp_nxt     = drv_oe_nxt && drive_p;
		mn_nxt     = drv_oe_nxt && drive_n;
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			motor_p_oe <= 1'b1;
			motor_n_oe <= 1'b1;
			motor_p_o  <= 1'b0;
			motor_n_o  <= 1'b0;
		end else begin
			motor_p_oe <= drv_oe_nxt;
			motor_n_oe <= drv_oe_nxt;
			motor_p_o  <= mp_nxt;
			motor_n_o  <= mn_nxt;
		end
	end

	assign pulse_running    = run_r;
	assign iface_pulse_mode = iface_r;
	assign deep_sleep       = (state_r == deep_sleep_state);

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	sequence enter_quick_s;
		(state_r == waking_state) ##1 (state_r == quick_state);
	endsequence

	motor_tristate_a: assert property (                     // R3
		(state_r != quick_state) |-> (!motor_p_oe && !motor_n_oe))
		else $error("motor driven outside quick state");

	wake_length_a: assert property (                        // R4
		enter_quick_s |-> ($past(wake_cnt_r, 1) == 32'(WAKE_CYC - 1)))
		else $error("wake interval wrong length");

	pulse_quick_a: assert property (                        // R5
		pulse_go |-> ($past(state_r) == quick_state))
		else $error("pulse issued while not awake");

	trigger_wakes_a: assert property (                      // R6
		(trigger_cmd && state_r == deep_sleep_state) |=> (state_r == waking_state))
		else $error("trigger did not wake");

	running_no_sleep_a: assert property (                   // R7
		(run_r && state_r == quick_state) |=> (state_r == quick_state))
		else $error("slept while pulse running");

	quick_mode_a: assert property (                         // R8
		(mode_r == MODE_QUICK && state_r == deep_sleep_state) |=> (state_r == waking_state))
		else $error("quick mode left device asleep");

	timeout_sleep_a: assert property (                      // R10
		(mode_r == MODE_AUTO && state_r == quick_state && hold_r && expire
			&& !trigger_cmd && !serial_addressed) |=> (!hold_r) ##1 (state_r == deep_sleep_state))
		else $error("automatic timeout did not sleep");

	addr_restart_a: assert property (                       // R11
		serial_addressed |=> (steps_r == 8'h0) && hold_r)
		else $error("addressing did not restart timeout");

	trig_no_sleep_a: assert property (                      // R12
		(trig_s && state_r == quick_state) |=> (state_r == quick_state))
		else $error("slept while trigger pin high");

	iface_hold_a: assert property (                         // R17
		captured_r |=> (captured_r && $stable(iface_r)))
		else $error("interface mode changed after capture");

endmodule : hpsm_top

// ### tb/hpsm_host_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Serial bus host: trigger commands and addressing
// ---------------------------------------------------------------
module hpsm_host_model (
	input  wire logic clock,
	output logic      trigger_cmd,
	output logic      serial_addressed
);
	initial begin
		trigger_cmd      = 1'b0;
		serial_addressed = 1'b0;
	end

	// One-cycle trigger command
	task automatic trig();
		@(posedge clock);
		trigger_cmd <= 1'b1;
		@(posedge clock);
		trigger_cmd <= 1'b0;
	endtask : trig

	// One-cycle addressing event
	task automatic addr();
		@(posedge clock);
		serial_addressed <= 1'b1;
		@(posedge clock);
		serial_addressed <= 1'b0;
	endtask : addr
endmodule : hpsm_host_model

// ### tb/hpsm_top_test.sv
`timescale 1ns/1ps
module hpsm_top_test;
	import hpsm_pkg::*;
	localparam int unsigned STEP = 20;
	localparam int unsigned WAKE = 10;
	logic        clock, resetn, psel, penable, pwrite, pready, pslverr, err;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic        iface_sel_pin, trig_pin, trigger_cmd, serial_addressed;
	logic        waveform_busy, hold_busy, drive_p, drive_n, pulse_go;
	logic        pulse_running, iface_pulse_mode, deep_sleep;
	logic        motor_p_o, motor_p_oe, motor_n_o, motor_n_oe;
	int          miscompares, checks, n, busy_left;

	hpsm_top #(.STEP_CYC(STEP), .WAKE_CYC(WAKE)) i_hpsm_top (.clock, .resetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .iface_sel_pin,
		.trig_pin, .trigger_cmd, .serial_addressed, .waveform_busy, .drive_p, .drive_n,
		.pulse_go, .pulse_running, .iface_pulse_mode, .deep_sleep, .motor_p_o,
		.motor_p_oe, .motor_n_o, .motor_n_oe);
	hpsm_host_model i_hpsm_host_model (.clock, .trigger_cmd, .serial_addressed);

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// ---------------------------------------------------------------
	// Haptic engine stand-in: busy for 8 cycles per pulse
	// ---------------------------------------------------------------
	always @(posedge clock) begin
		if (pulse_go === 1'b1) busy_left <= 8;
		else if (busy_left > 0) busy_left <= busy_left - 1;
		waveform_busy <= hold_busy || pulse_go === 1'b1 || busy_left > 1;
	end

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clock);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic mode(input logic [1:0] m, input logic [7:0] t);
		apb(1'b1, {24'h0, SETTINGS_OFS}, {16'h0, t, 6'h0, m});
	endtask : mode

	task automatic cyc(input int k);
		repeat (k) @(posedge clock);
	endtask : cyc

	// Cycles from the sampled trigger to the pulse start
	task automatic lat(output int k);
		i_hpsm_host_model.trig();
		k = 0;
		do begin
			@(posedge clock);
			#1;
			k++;
		end while (pulse_go !== 1'b1 && k < 100);
	endtask : lat

	task automatic do_reset(input logic strap);
		iface_sel_pin <= strap;
		resetn        <= 1'b0;
		cyc(3);
		resetn        <= 1'b1;
		cyc(6);
	endtask : do_reset

	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : final_report

	// ---------------------------------------------------------------
	// Tests
	// ---------------------------------------------------------------
	initial begin
		{resetn, psel, penable, pwrite, trig_pin, hold_busy, drive_p, drive_n} = '0;
		{paddr, pwdata, miscompares, checks} = '0;
		iface_sel_pin = 1'b0;
		do_reset(1'b0);
		check(iface_pulse_mode, 1'b0);
		apb(1'b0, {24'h0, STATE_OFS}, 32'h0);
		check(rd[ST_SLEEP_BIT], 1'b0);
		check(rd[ST_IFACE_BIT], 1'b0);
		apb(1'b0, 32'h10, 32'h0);
		check(err, 1'b1);
		mode(MODE_QUICK, 8'h02);
		apb(1'b0, {24'h0, SETTINGS_OFS}, 32'h0);
		check(rd, {16'h0, 8'h02, 6'h0, MODE_QUICK});
		iface_sel_pin <= 1'b1;
		cyc(10);
		check(iface_pulse_mode, 1'b0);
		drive_p <= 1'b1;
		lat(n);
		check(n, 1);
		cyc(3);
		check(pulse_running, 1'b1);
		check({motor_p_oe, motor_p_o}, 2'b11);
		check({motor_n_oe, motor_n_o}, 2'b10);
		cyc(100);
		check(deep_sleep, 1'b0);
		mode(MODE_DEEP, 8'h02);
		cyc(30);
		check(deep_sleep, 1'b1);
		check({motor_p_oe, motor_n_oe}, 2'b00);
		check({motor_p_o, motor_n_o}, 2'b00);
		apb(1'b0, {24'h0, STATE_OFS}, 32'h0);
		check(rd[ST_SLEEP_BIT], 1'b1);
		lat(n);
		check(n, 1 + WAKE);
		cyc(30);
		check(deep_sleep, 1'b1);
		trig_pin <= 1'b1;
		cyc(30);
		check(deep_sleep, 1'b0);
		cyc(30);
		check(deep_sleep, 1'b0);
		trig_pin <= 1'b0;
		cyc(10);
		check(deep_sleep, 1'b1);
		mode(MODE_QUICK, 8'h02);
		cyc(20);
		check(deep_sleep, 1'b0);
		mode(MODE_AUTO, 8'h02);
		i_hpsm_host_model.addr();
		cyc(30);
		check(deep_sleep, 1'b0);
		cyc(50);
		check(deep_sleep, 1'b1);
		i_hpsm_host_model.addr();
		cyc(38);
		i_hpsm_host_model.addr();
		cyc(38);
		check(deep_sleep, 1'b0);
		cyc(50);
		check(deep_sleep, 1'b1);
		mode(MODE_AUTO, 8'h01);
		hold_busy <= 1'b1;
		i_hpsm_host_model.addr();
		cyc(80);
		check(deep_sleep, 1'b0);
		check(pulse_running, 1'b1);
		apb(1'b0, {24'h0, STATE_OFS}, 32'h0);
		check(rd[ST_RUN_BIT], 1'b1);
		trig_pin  <= 1'b1;
		hold_busy <= 1'b0;
		cyc(60);
		check(deep_sleep, 1'b0);
		check(pulse_running, 1'b0);
		trig_pin <= 1'b0;
		cyc(12);
		check(deep_sleep, 1'b0);
		cyc(40);
		check(deep_sleep, 1'b1);
		do_reset(1'b1);
		check(iface_pulse_mode, 1'b1);
		check(deep_sleep, 1'b0);
		final_report();
	end

	initial begin
		#200_000;
		miscompares++;
		final_report();
	end
endmodule : hpsm_top_test
